// File: csd_pkg.sv
// shared constants and types for the counter setup command decoder
package csd_pkg;

  // command headers as delivered by the front-end tokenizer
  typedef enum logic [3:0] {
    CMD_FREQ_ACQ    = 4'b0000,
    CMD_LEVEL_ACQ   = 4'b0001,
    CMD_MAN_ATTEN   = 4'b0010,
    CMD_MAN_FREQ    = 4'b0011,
    CMD_IN2_ATTEN   = 4'b0100,
    CMD_AUX_SELECT  = 4'b0101,
    CMD_BURST_EN    = 4'b0110,
    CMD_BURST_KIND  = 4'b0111,
    CMD_BURST_POL   = 4'b1000,
    CMD_BURST_RANGE = 4'b1001
  } csd_cmd_t;

  // frequency unit after case folding
  typedef enum logic [2:0] {
    UNIT_HZ  = 3'b000,
    UNIT_KHZ = 3'b001,
    UNIT_MHZ = 3'b010,
    UNIT_GHZ = 3'b011,
    UNIT_BAD = 3'b100
  } csd_unit_t;

  // initial values restored by reset and preset
  localparam logic RST_FREQ_ACQ = 1'b0;
  localparam logic RST_LEVEL_ACQ = 1'b0;
  localparam logic [2:0] RST_MAN_ATTEN = 3'h0;
  localparam logic [15:0] RST_MAN_FREQ_MHZ = 16'h0258;
  localparam logic RST_IN2_ATTEN = 1'b1;
  localparam logic [2:0] RST_AUX_SEL = 3'h0;
  localparam logic RST_BURST_EN = 1'b0;
  localparam logic [1:0] RST_BURST_KIND = 2'h0;
  localparam logic RST_BURST_POL = 1'b0;
  localparam logic RST_BURST_RANGE = 1'b0;

  // largest legal codes per setting, and least manual frequency
  localparam logic [7:0] MAX_BIT_CODE = 8'h01;
  localparam logic [7:0] MAX_ATTEN_CODE = 8'h07;
  localparam logic [7:0] MAX_AUX_CODE = 8'h06;
  localparam logic [7:0] MAX_KIND_CODE = 8'h02;
  localparam logic [45:0] MIN_MAN_FREQ_MHZ = 46'h0000_0000_0258;

  // burst measurement kinds
  localparam logic [1:0] KIND_CARRIER = 2'h0;
  localparam logic [1:0] KIND_WIDTH = 2'h1;
  localparam logic [1:0] KIND_PERIOD = 2'h2;

  // auxiliary output selector codes
  localparam logic [2:0] AUX_IDLE = 3'h0;
  localparam logic [2:0] AUX_PASS_FAIL = 3'h1;
  localparam logic [2:0] AUX_COUNT_END = 3'h2;
  localparam logic [2:0] AUX_BURST_DET = 3'h3;
  localparam logic [2:0] AUX_INT_GATE = 3'h4;
  localparam logic [2:0] AUX_RESTART = 3'h5;
  localparam logic [2:0] AUX_ACQ = 3'h6;

  // aux low pulse: least width 1 us at 100 ns clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int AUX_PULSE_NS = 1000;
  localparam int AUX_PULSE_CYCLES = (AUX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: csd_aux_out.sv
// rear auxiliary output selector and pulse former
`timescale 1ns/1ns
module csd_aux_out
  import csd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // selection
  input wire logic [2:0] aux_sel,
  // internal measurement signals
  input wire logic pass_fail,
  input wire logic template_en,
  input wire logic count_end,
  input wire logic burst_det,
  input wire logic int_gate,
  input wire logic restart_exec,
  input wire logic acq_busy,
  // pin
  output logic aux_out
);

  localparam logic [7:0] PULSE_LEN = 8'(AUX_PULSE_CYCLES);

  logic [7:0] pulse_cnt_r, pulse_cnt_nxt;
  logic aux_r, aux_nxt;
  logic trig;

  always_comb begin
    trig = 1'b0;
    pulse_cnt_nxt = pulse_cnt_r;
    aux_nxt = 1'b1;
    // (R10) count end pulse
    if (aux_sel == AUX_COUNT_END) begin
      trig = count_end;
    end
    // (R13) restart pulse
    if (aux_sel == AUX_RESTART) begin
      trig = restart_exec;
    end
    // a new event during a pulse restarts it rather than merging silently
    if (trig) begin
      pulse_cnt_nxt = PULSE_LEN;
    end else if (pulse_cnt_r != 8'h00) begin
      pulse_cnt_nxt = pulse_cnt_r - 8'h01;
    end
    unique case (aux_sel)
      // (R9) pass fail level
      AUX_PASS_FAIL: aux_nxt = template_en ? pass_fail : 1'b1;
      AUX_COUNT_END: aux_nxt = (pulse_cnt_nxt == 8'h00);
      // (R11) burst detect copy
      AUX_BURST_DET: aux_nxt = burst_det;
      // (R12) gate copy
      AUX_INT_GATE: aux_nxt = int_gate;
      AUX_RESTART: aux_nxt = (pulse_cnt_nxt == 8'h00);
      // (R14) low while acquiring
      AUX_ACQ: aux_nxt = ~acq_busy;
      AUX_IDLE: aux_nxt = 1'b1;
      default: aux_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_cnt_r <= 8'h00;
      aux_r <= 1'b1;
    end else begin
      pulse_cnt_r <= pulse_cnt_nxt;
      aux_r <= aux_nxt;
    end
  end

  assign aux_out = aux_r;

endmodule

// File: csd_decoder.sv
// counter setup command decoder, settings store and burst interval timer
//
// Operation
// (R1) frequency acquisition: 0 automatic (initial), 1 manual
// (R2) second argument 1 copies last measured frequency into manual frequency
// (R3) level acquisition: 0 automatic (initial), 1 manual
// (R4) second argument 1 copies last measured level into attenuation code
// (R5) attenuation code 0..7, 7 is 0 dB, 6 dB steps, initial 0
// (R6) manual frequency 600 MHz to maximum, truncated to whole MHz
// (R7) input 2 attenuator: 0 through, 1 20 dB engaged (initial)
// (R8) aux selector 0..6, initial 0, codes pick six internal signals
// (R9) pass/fail high within limits, low outside, high if template off
// (R10) count end gives one low pulse per finished measurement
// (R11) burst detect selection shows internal burst detection signal
// (R12) gate selection reproduces the internal count gate
// (R13) restart selection gives one low pulse per restart
// (R14) acquisition selection is low while acquisition runs
// (R15) burst enable: 0 continuous wave (initial), 1 burst
// (R16) burst kind: 0 carrier (initial), 1 width, 2 period
// (R17) width times on interval if positive, off interval if negative
// (R18) period times on-to-on edges if positive, off-to-off if negative
// (R19) burst polarity: 0 positive (initial), 1 negative
// (R20) burst range: 0 wide 1 us..0.1 s (initial), 1 narrow
// (R21) controller picks wide only above 600 MHz, narrow above 1 GHz
// (R22) unit suffixes accepted in any case, hertz when absent
// (R23) out of range data raises execution error, value not applied
// (R24) preset returns every setting here to its initial value
// (R25) query answers header and stored code, setting unchanged
`timescale 1ns/1ns
module csd_decoder
  import csd_pkg::*;
#(
  parameter int FMAX_MHZ = 40000,
  parameter int TIMER_W = 24
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // tokenized command from the bus front end
  input wire logic cmd_valid,
  input wire logic cmd_query,
  input wire csd_cmd_t cmd_code,
  input wire logic [35:0] cmd_arg,
  input wire logic cmd_second_present,
  input wire logic [7:0] cmd_second,
  input wire logic [23:0] cmd_suffix,
  input wire logic [1:0] cmd_suffix_len,
  input wire logic preset,
  // measurement hardware status
  input wire logic [15:0] meas_freq_mhz,
  input wire logic [2:0] meas_level_code,
  input wire logic pass_fail,
  input wire logic template_en,
  input wire logic count_end,
  input wire logic burst_det,
  input wire logic int_gate,
  input wire logic restart_exec,
  input wire logic acq_busy,
  // settings to the measurement hardware
  output logic freq_acq_manual,
  output logic level_acq_manual,
  output logic [2:0] man_atten_code,
  output logic [15:0] man_freq_mhz,
  output logic in2_atten_on,
  output logic [2:0] aux_sel,
  output logic burst_en,
  output logic [1:0] burst_kind,
  output logic burst_pol_neg,
  output logic burst_range_narrow,
  // query answer and error event
  output logic resp_valid,
  output csd_cmd_t resp_code,
  output logic [15:0] resp_value,
  output logic exe_err,
  // burst interval result in clock cycles
  output logic [TIMER_W-1:0] burst_time,
  output logic burst_time_valid,
  // rear pin
  output logic aux_out
);

  localparam logic [45:0] FMAX = 46'(FMAX_MHZ);

  function automatic logic [7:0] fold_upper(input logic [7:0] c);
    fold_upper = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
  endfunction

  function automatic logic code_ok(input logic [7:0] v, input logic [7:0] max);
    code_ok = (v <= max);
  endfunction

  logic freq_acq_r, freq_acq_nxt;
  logic level_acq_r, level_acq_nxt;
  logic [2:0] atten_r, atten_nxt;
  logic [15:0] mfreq_r, mfreq_nxt;
  logic in2_r, in2_nxt;
  logic [2:0] aux_sel_r, aux_sel_nxt;
  logic bst_r, bst_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic pol_r, pol_nxt;
  logic range_r, range_nxt;
  logic resp_valid_r, resp_valid_nxt;
  csd_cmd_t resp_code_r, resp_code_nxt;
  logic [15:0] resp_value_r, resp_value_nxt;
  logic err_r, err_nxt;

  logic [7:0] c0, c1, c2;
  csd_unit_t unit;
  logic [45:0] freq_mhz;
  logic [7:0] n8;
  logic s_ok;

  // (R22) suffix folding
  always_comb begin
    c0 = fold_upper(cmd_suffix[7:0]);
    c1 = fold_upper(cmd_suffix[15:8]);
    c2 = fold_upper(cmd_suffix[23:16]);
    unit = UNIT_BAD;
    unique case (cmd_suffix_len)
      2'd0: unit = UNIT_HZ;
      2'd1: begin
        if (c0 == 8'h47) unit = UNIT_GHZ;
        else if (c0 == 8'h4B) unit = UNIT_KHZ;
      end
      2'd2: begin
        if (c0 == 8'h48 && c1 == 8'h5A) unit = UNIT_HZ;
        else if (c0 == 8'h4D && c1 == 8'h41) unit = UNIT_MHZ;
      end
      2'd3: begin
        if (c1 == 8'h48 && c2 == 8'h5A) begin
          if (c0 == 8'h47) unit = UNIT_GHZ;
          else if (c0 == 8'h4D) unit = UNIT_MHZ;
          else if (c0 == 8'h4B) unit = UNIT_KHZ;
        end
      end
    endcase
  end

  // (R6) whole MHz by truncation
  always_comb begin
    unique case (unit)
      UNIT_GHZ: freq_mhz = 46'({10'h000, cmd_arg} * 46'd1000);
      UNIT_MHZ: freq_mhz = {10'h000, cmd_arg};
      UNIT_KHZ: freq_mhz = {10'h000, cmd_arg / 36'd1000};
      UNIT_HZ: freq_mhz = {10'h000, cmd_arg / 36'd1000000};
      default: freq_mhz = 46'h0000_0000_0000;
    endcase
  end

  assign n8 = (cmd_arg > 36'd255) ? 8'hFF : cmd_arg[7:0];
  assign s_ok = !cmd_second_present || code_ok(cmd_second, MAX_BIT_CODE);

  always_comb begin
    freq_acq_nxt = freq_acq_r;
    level_acq_nxt = level_acq_r;
    atten_nxt = atten_r;
    mfreq_nxt = mfreq_r;
    in2_nxt = in2_r;
    aux_sel_nxt = aux_sel_r;
    bst_nxt = bst_r;
    kind_nxt = kind_r;
    pol_nxt = pol_r;
    range_nxt = range_r;
    resp_valid_nxt = 1'b0;
    resp_code_nxt = resp_code_r;
    resp_value_nxt = resp_value_r;
    err_nxt = 1'b0;
    if (preset) begin
      // (R24) preset restores initial values
      freq_acq_nxt = RST_FREQ_ACQ;
      level_acq_nxt = RST_LEVEL_ACQ;
      atten_nxt = RST_MAN_ATTEN;
      mfreq_nxt = RST_MAN_FREQ_MHZ;
      in2_nxt = RST_IN2_ATTEN;
      aux_sel_nxt = RST_AUX_SEL;
      bst_nxt = RST_BURST_EN;
      kind_nxt = RST_BURST_KIND;
      pol_nxt = RST_BURST_POL;
      range_nxt = RST_BURST_RANGE;
    end else if (cmd_valid && cmd_query) begin
      // (R25) query reads stored code
      resp_valid_nxt = 1'b1;
      resp_code_nxt = cmd_code;
      unique case (cmd_code)
        CMD_FREQ_ACQ: resp_value_nxt = {15'h0000, freq_acq_r};
        CMD_LEVEL_ACQ: resp_value_nxt = {15'h0000, level_acq_r};
        CMD_MAN_ATTEN: resp_value_nxt = {13'h0000, atten_r};
        CMD_MAN_FREQ: resp_value_nxt = mfreq_r;
        CMD_IN2_ATTEN: resp_value_nxt = {15'h0000, in2_r};
        CMD_AUX_SELECT: resp_value_nxt = {13'h0000, aux_sel_r};
        CMD_BURST_EN: resp_value_nxt = {15'h0000, bst_r};
        CMD_BURST_KIND: resp_value_nxt = {14'h0000, kind_r};
        CMD_BURST_POL: resp_value_nxt = {15'h0000, pol_r};
        CMD_BURST_RANGE: resp_value_nxt = {15'h0000, range_r};
        default: begin
          resp_valid_nxt = 1'b0;
          err_nxt = 1'b1;
        end
      endcase
    end else if (cmd_valid) begin
      // (R23) range check before apply
      unique case (cmd_code)
        CMD_FREQ_ACQ: begin
          if (code_ok(n8, MAX_BIT_CODE) && s_ok) begin
            // (R1) acquisition mode
            freq_acq_nxt = n8[0];
            // (R2) adopt measured frequency
            if (cmd_second_present && cmd_second[0]) mfreq_nxt = meas_freq_mhz;
          end else err_nxt = 1'b1;
        end
        CMD_LEVEL_ACQ: begin
          if (code_ok(n8, MAX_BIT_CODE) && s_ok) begin
            // (R3) level mode
            level_acq_nxt = n8[0];
            // (R4) adopt measured level
            if (cmd_second_present && cmd_second[0]) atten_nxt = meas_level_code;
          end else err_nxt = 1'b1;
        end
        CMD_MAN_ATTEN: begin
          // (R5) attenuation code
          if (code_ok(n8, MAX_ATTEN_CODE)) atten_nxt = n8[2:0];
          else err_nxt = 1'b1;
        end
        CMD_MAN_FREQ: begin
          // (R6) frequency window
          if (unit != UNIT_BAD && freq_mhz >= MIN_MAN_FREQ_MHZ && freq_mhz <= FMAX) begin
            mfreq_nxt = freq_mhz[15:0];
          end else err_nxt = 1'b1;
        end
        CMD_IN2_ATTEN: begin
          // (R7) input 2 pad
          if (code_ok(n8, MAX_BIT_CODE)) in2_nxt = n8[0];
          else err_nxt = 1'b1;
        end
        CMD_AUX_SELECT: begin
          // (R8) aux source
          if (code_ok(n8, MAX_AUX_CODE)) aux_sel_nxt = n8[2:0];
          else err_nxt = 1'b1;
        end
        CMD_BURST_EN: begin
          // (R15) burst enable
          if (code_ok(n8, MAX_BIT_CODE)) bst_nxt = n8[0];
          else err_nxt = 1'b1;
        end
        CMD_BURST_KIND: begin
          // (R16) burst kind
          if (code_ok(n8, MAX_KIND_CODE)) kind_nxt = n8[1:0];
          else err_nxt = 1'b1;
        end
        CMD_BURST_POL: begin
          // (R19) burst polarity
          if (code_ok(n8, MAX_BIT_CODE)) pol_nxt = n8[0];
          else err_nxt = 1'b1;
        end
        CMD_BURST_RANGE: begin
          // (R20) width range, carrier limits left to the controller
          if (code_ok(n8, MAX_BIT_CODE)) range_nxt = n8[0];
          else err_nxt = 1'b1;
        end
        default: err_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      freq_acq_r <= RST_FREQ_ACQ;
      level_acq_r <= RST_LEVEL_ACQ;
      atten_r <= RST_MAN_ATTEN;
      mfreq_r <= RST_MAN_FREQ_MHZ;
      in2_r <= RST_IN2_ATTEN;
      aux_sel_r <= RST_AUX_SEL;
      bst_r <= RST_BURST_EN;
      kind_r <= RST_BURST_KIND;
      pol_r <= RST_BURST_POL;
      range_r <= RST_BURST_RANGE;
      resp_valid_r <= 1'b0;
      resp_code_r <= CMD_FREQ_ACQ;
      resp_value_r <= 16'h0000;
      err_r <= 1'b0;
    end else begin
      freq_acq_r <= freq_acq_nxt;
      level_acq_r <= level_acq_nxt;
      atten_r <= atten_nxt;
      mfreq_r <= mfreq_nxt;
      in2_r <= in2_nxt;
      aux_sel_r <= aux_sel_nxt;
      bst_r <= bst_nxt;
      kind_r <= kind_nxt;
      pol_r <= pol_nxt;
      range_r <= range_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_code_r <= resp_code_nxt;
      resp_value_r <= resp_value_nxt;
      err_r <= err_nxt;
    end
  end

  // burst interval timer; polarity flips which level counts as on
  logic det_d_r, det_d_nxt;
  logic armed_r, armed_nxt;
  logic [TIMER_W-1:0] tcnt_r, tcnt_nxt;
  logic [TIMER_W-1:0] btime_r, btime_nxt;
  logic bvalid_r, bvalid_nxt;
  logic act, act_d, rise, fall, timing;

  always_comb begin
    act = burst_det ^ pol_r;
    act_d = det_d_r ^ pol_r;
    rise = act && !act_d;
    fall = !act && act_d;
    timing = bst_r && (kind_r == KIND_WIDTH || kind_r == KIND_PERIOD);
    det_d_nxt = burst_det;
    armed_nxt = armed_r;
    tcnt_nxt = (tcnt_r == '1) ? tcnt_r : tcnt_r + 1'b1;
    btime_nxt = btime_r;
    bvalid_nxt = 1'b0;
    if (!timing) begin
      armed_nxt = 1'b0;
      tcnt_nxt = '0;
    end else if (kind_r == KIND_WIDTH) begin
      // (R17) on or off interval
      if (rise) begin
        armed_nxt = 1'b1;
        tcnt_nxt = '0;
      end else if (fall && armed_r) begin
        btime_nxt = tcnt_r;
        bvalid_nxt = 1'b1;
        armed_nxt = 1'b0;
      end
    end else if (rise) begin
      // (R18) edge to like edge
      armed_nxt = 1'b1;
      tcnt_nxt = '0;
      if (armed_r) begin
        btime_nxt = tcnt_r;
        bvalid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      det_d_r <= 1'b0;
      armed_r <= 1'b0;
      tcnt_r <= '0;
      btime_r <= '0;
      bvalid_r <= 1'b0;
    end else begin
      det_d_r <= det_d_nxt;
      armed_r <= armed_nxt;
      tcnt_r <= tcnt_nxt;
      btime_r <= btime_nxt;
      bvalid_r <= bvalid_nxt;
    end
  end

  csd_aux_out u_aux (
    .clk(clk),
    .reset(reset),
    .aux_sel(aux_sel_r),
    .pass_fail(pass_fail),
    .template_en(template_en),
    .count_end(count_end),
    .burst_det(burst_det),
    .int_gate(int_gate),
    .restart_exec(restart_exec),
    .acq_busy(acq_busy),
    .aux_out(aux_out)
  );

  assign freq_acq_manual = freq_acq_r;
  assign level_acq_manual = level_acq_r;
  assign man_atten_code = atten_r;
  assign man_freq_mhz = mfreq_r;
  assign in2_atten_on = in2_r;
  assign aux_sel = aux_sel_r;
  assign burst_en = bst_r;
  assign burst_kind = kind_r;
  assign burst_pol_neg = pol_r;
  assign burst_range_narrow = range_r;
  assign resp_valid = resp_valid_r;
  assign resp_code = resp_code_r;
  assign resp_value = resp_value_r;
  assign exe_err = err_r;
  assign burst_time = btime_r;
  assign burst_time_valid = bvalid_r;

endmodule

// File: csd_checker.sv
// assertions on the decoder top ports
`timescale 1ns/1ns
module csd_checker
  import csd_pkg::*;
#(
  parameter int FMAX_MHZ = 40000
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // command and sources
  input wire logic cmd_valid,
  input wire logic cmd_query,
  input wire csd_cmd_t cmd_code,
  input wire logic [35:0] cmd_arg,
  input wire logic preset,
  input wire logic pass_fail,
  input wire logic template_en,
  input wire logic count_end,
  input wire logic int_gate,
  input wire logic acq_busy,
  // outputs
  input wire logic [2:0] aux_sel,
  input wire logic [2:0] man_atten_code,
  input wire logic [15:0] man_freq_mhz,
  input wire logic resp_valid,
  input wire logic exe_err,
  input wire logic burst_time_valid,
  input wire logic aux_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  assign take = cmd_valid && !preset;
  // past reset check keeps a short reset from aliasing old selections
  property aux_is(logic [2:0] c, logic v);
    !$past(reset) && $past(aux_sel) == c |-> aux_out == v;
  endproperty
  chk_sel_range: assert property (aux_sel <= AUX_ACQ)
    else $error("aux selector above six");
  chk_freq_bounds: assert property (man_freq_mhz >= 16'h0258 && man_freq_mhz <= FMAX_MHZ)
    else $error("manual frequency out of bounds");
  chk_query_answer: assert property (take && cmd_query && cmd_code <= CMD_BURST_RANGE |=> resp_valid)
    else $error("query not answered");
  chk_answer_cause: assert property (resp_valid |-> $past(take && cmd_query))
    else $error("answer without query");
  chk_atten_refuse: assert property (take && !cmd_query && cmd_code == CMD_MAN_ATTEN &&
    cmd_arg > 36'h0_0000_0007 |=> exe_err && $stable(man_atten_code))
    else $error("bad attenuation code applied");
  chk_preset_init: assert property (preset |=> aux_sel == 3'h0 && man_freq_mhz == 16'h0258 &&
    man_atten_code == 3'h0)
    else $error("preset left a setting");
  chk_idle_high: assert property (aux_is(AUX_IDLE, 1'b1))
    else $error("idle aux not high");
  chk_pass_fail: assert property (aux_is(AUX_PASS_FAIL, $past(template_en) ? $past(pass_fail) : 1'b1))
    else $error("pass fail aux wrong");
  chk_count_low: assert property (!$past(reset) && aux_sel == AUX_COUNT_END && count_end
    |=> (!aux_out) [*8])
    else $error("count end pulse too short");
  chk_gate_copy: assert property (aux_is(AUX_INT_GATE, $past(int_gate)))
    else $error("gate not copied");
  chk_acq_low: assert property (aux_is(AUX_ACQ, !$past(acq_busy)))
    else $error("acquisition aux wrong");
  cover property (take && cmd_query);
  cover property (exe_err);
  cover property (burst_time_valid);
  cover property (aux_sel == AUX_COUNT_END && count_end);
endmodule

// File: csd_host_model.sv
// bus controller model issuing tokenized commands
`timescale 1ns/1ns
module csd_host_model
  import csd_pkg::*;
(
  // clock
  input wire logic clk,
  // command lines
  output logic cmd_valid = 1'b0,
  output logic cmd_query = 1'b0,
  output csd_cmd_t cmd_code = CMD_FREQ_ACQ,
  output logic [35:0] cmd_arg = 36'h0_0000_0000,
  output logic cmd_second_present = 1'b0,
  output logic [7:0] cmd_second = 8'h00,
  output logic [23:0] cmd_suffix = 24'h00_0000,
  output logic [1:0] cmd_suffix_len = 2'h0
);
  // range picked by caller per carrier
  task automatic send(input logic q, input csd_cmd_t c, input logic [35:0] a,
    input logic [23:0] sf, input logic [1:0] sl, input logic p, input logic [7:0] s);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_query = q;
    cmd_code = c;
    cmd_arg = a;
    cmd_suffix = sf;
    cmd_suffix_len = sl;
    cmd_second_present = p;
    cmd_second = s;
    @(negedge clk);
    cmd_valid = 1'b0;
    // released data must not look stale
    cmd_arg = ~a;
    cmd_suffix = ~sf;
    cmd_second = ~s;
  endtask
endmodule

// File: tb.sv
// self-checking bench for the setup command decoder
`timescale 1ns/1ns
module tb;
  import csd_pkg::*;
  logic clk = 0, reset = 1, preset = 0, pass_fail = 0, template_en = 0, count_end = 0;
  logic burst_det = 0, int_gate = 0, restart_exec = 0, acq_busy = 0;
  logic [15:0] meas_freq_mhz = 16'h0000;
  logic [2:0] meas_level_code = 3'h0;
  logic cmd_valid, cmd_query, cmd_second_present, freq_acq_manual, level_acq_manual;
  logic in2_atten_on, burst_en, burst_pol_neg, burst_range_narrow, resp_valid, exe_err;
  logic burst_time_valid, aux_out;
  csd_cmd_t cmd_code, resp_code;
  logic [35:0] cmd_arg;
  logic [7:0] cmd_second;
  logic [23:0] cmd_suffix, burst_time;
  logic [1:0] cmd_suffix_len, burst_kind;
  logic [2:0] man_atten_code, aux_sel;
  logic [15:0] man_freq_mhz, resp_value;
  int bad_count = 0, check_count = 0, cyc = 0;
  csd_cmd_t tc [9] = '{CMD_FREQ_ACQ, CMD_LEVEL_ACQ, CMD_MAN_ATTEN, CMD_IN2_ATTEN,
    CMD_AUX_SELECT, CMD_BURST_EN, CMD_BURST_KIND, CMD_BURST_POL, CMD_BURST_RANGE};
  int tm [9] = '{1, 1, 7, 1, 6, 1, 2, 1, 1};
  csd_host_model csd_host_model_inst (.clk, .cmd_valid, .cmd_query, .cmd_code, .cmd_arg,
    .cmd_second_present, .cmd_second, .cmd_suffix, .cmd_suffix_len);
  csd_decoder #(.FMAX_MHZ(40000), .TIMER_W(24)) csd_decoder_inst (.clk, .reset, .cmd_valid,
    .cmd_query, .cmd_code, .cmd_arg, .cmd_second_present, .cmd_second, .cmd_suffix,
    .cmd_suffix_len, .preset, .meas_freq_mhz, .meas_level_code, .pass_fail, .template_en,
    .count_end, .burst_det, .int_gate, .restart_exec, .acq_busy, .freq_acq_manual,
    .level_acq_manual, .man_atten_code, .man_freq_mhz, .in2_atten_on, .aux_sel, .burst_en,
    .burst_kind, .burst_pol_neg, .burst_range_narrow, .resp_valid, .resp_code, .resp_value,
    .exe_err, .burst_time, .burst_time_valid, .aux_out);
  initial forever #50 clk = ~clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // run is about 240 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic st(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic sc(input logic q, input csd_cmd_t c, input logic [35:0] a,
    input logic [23:0] sf = 0, input logic [1:0] sl = 0, input logic p = 0, input logic [7:0] s = 0);
    csd_host_model_inst.send(q, c, a, sf, sl, p, s);
  endtask
  function automatic logic [15:0] cur(csd_cmd_t c);
    case (c)
      CMD_FREQ_ACQ: cur = 16'(freq_acq_manual);
      CMD_LEVEL_ACQ: cur = 16'(level_acq_manual);
      CMD_MAN_ATTEN: cur = 16'(man_atten_code);
      CMD_IN2_ATTEN: cur = 16'(in2_atten_on);
      CMD_AUX_SELECT: cur = 16'(aux_sel);
      CMD_BURST_EN: cur = 16'(burst_en);
      CMD_BURST_KIND: cur = 16'(burst_kind);
      CMD_BURST_POL: cur = 16'(burst_pol_neg);
      default: cur = 16'(burst_range_narrow);
    endcase
  endfunction
  task automatic init_chk();
    chk({freq_acq_manual, level_acq_manual, man_atten_code, in2_atten_on, aux_sel, burst_en,
      burst_kind, burst_pol_neg, burst_range_narrow}, 32'h0000_0100);
    chk({resp_valid, aux_out, man_freq_mhz}, 32'h0001_0258);
  endtask
  task automatic t_codes();
    for (int k = 0; k < 9; k++) begin
      for (int i = 0; i <= tm[k] + 1; i++) begin
        sc(0, tc[k], 36'(i));
        if (i <= tm[k]) chk(cur(tc[k]), i);
        else chk({exe_err, cur(tc[k])}, {1'b1, 16'(tm[k])});
      end
      sc(1, tc[k], 36'h0_0000_0000);
      chk({resp_valid, resp_code, resp_value}, {1'b1, tc[k], 16'(tm[k])});
      chk(cur(tc[k]), tm[k]);
    end
    sc(0, csd_cmd_t'(4'ha), 36'h0_0000_0000);
    chk(exe_err, 1);
    sc(1, csd_cmd_t'(4'hb), 36'h0_0000_0000);
    chk({exe_err, resp_valid}, 2'b10);
  endtask
  task automatic t_freq();
    sc(0, CMD_MAN_FREQ, 36'h0_0000_0002, 24'h7a_6867, 2'h3);
    chk(man_freq_mhz, 16'h07d0);
    sc(0, CMD_MAN_FREQ, 36'h0_0000_05dc, 24'h00_414d, 2'h2);
    chk(man_freq_mhz, 16'h05dc);
    sc(0, CMD_MAN_FREQ, 36'h0_29c8_693f);
    chk(man_freq_mhz, 16'h02bc);
    sc(0, CMD_MAN_FREQ, 36'h0_0000_0257, 24'h5a_484d, 2'h3);
    chk({exe_err, man_freq_mhz}, {1'b1, 16'h02bc});
    sc(0, CMD_MAN_FREQ, 36'h0_0000_9c41, 24'h5a_484d, 2'h3);
    chk({exe_err, man_freq_mhz}, {1'b1, 16'h02bc});
    sc(0, CMD_MAN_FREQ, 36'h0_000f_4240, 24'h00_006b, 2'h1);
    chk(man_freq_mhz, 16'h03e8);
    sc(1, CMD_MAN_FREQ, 36'h0_0000_0000);
    chk(resp_value, 16'h03e8);
  endtask
  task automatic t_second();
    meas_freq_mhz = 16'h0abc;
    meas_level_code = 3'h5;
    sc(0, CMD_FREQ_ACQ, 36'h0_0000_0001, 0, 0, 1, 8'h01);
    chk({freq_acq_manual, man_freq_mhz}, {1'b1, 16'h0abc});
    meas_freq_mhz = 16'h0bcd;
    sc(0, CMD_FREQ_ACQ, 36'h0_0000_0001, 0, 0, 1, 8'h00);
    chk(man_freq_mhz, 16'h0abc);
    sc(0, CMD_LEVEL_ACQ, 36'h0_0000_0001, 0, 0, 1, 8'h01);
    chk({level_acq_manual, man_atten_code}, {1'b1, 3'h5});
    sc(0, CMD_LEVEL_ACQ, 36'h0_0000_0000, 0, 0, 1, 8'h02);
    chk({exe_err, level_acq_manual}, 2'b11);
  endtask
  task automatic t_preset();
    sc(0, CMD_IN2_ATTEN, 36'h0_0000_0000);
    preset = 1;
    sc(0, CMD_BURST_EN, 36'h0_0000_0001);
    preset = 0;
    init_chk();
  endtask
  task automatic lvl(input int c, input logic v, input logic e);
    chk(aux_sel, c);
    pass_fail = v & (c == 1);
    burst_det = v & (c == 3);
    int_gate = v & (c == 4);
    acq_busy = v & (c == 6);
    st(2);
    chk(aux_out, e);
  endtask
  task automatic pls(input int c);
    int n;
    n = 0;
    sc(0, CMD_AUX_SELECT, 36'(c));
    st(2);
    count_end = (c == 2);
    restart_exec = (c == 5);
    st(1);
    count_end = 0;
    restart_exec = 0;
    repeat (14) begin
      n += (aux_out === 1'b0);
      st(1);
    end
    chk(n, AUX_PULSE_CYCLES);
  endtask
  task automatic t_aux();
    sc(0, CMD_AUX_SELECT, 36'h0_0000_0001);
    lvl(1, 0, 1);
    template_en = 1;
    lvl(1, 0, 0);
    lvl(1, 1, 1);
    for (int c = 3; c <= 6; c += 1 + (c == 4)) begin
      sc(0, CMD_AUX_SELECT, 36'(c));
      lvl(c, 1, c != 6);
      lvl(c, 0, c == 6);
    end
    pls(2);
    pls(5);
  endtask
  task automatic wbt(input logic [23:0] e);
    for (int k = 0; k < 20 && burst_time_valid !== 1'b1; k++) st(1);
    chk({burst_time_valid, burst_time}, {1'b1, e});
  endtask
  task automatic t_burst();
    sc(0, CMD_BURST_EN, 36'h0_0000_0001);
    sc(0, CMD_BURST_KIND, 36'h0_0000_0001);
    burst_det = 1;
    st(6);
    burst_det = 0;
    wbt(24'h00_0005);
    burst_det = 1;
    sc(0, CMD_BURST_POL, 36'h0_0000_0001);
    st(4);
    burst_det = 0;
    st(4);
    burst_det = 1;
    wbt(24'h00_0003);
    sc(0, CMD_BURST_POL, 36'h0_0000_0000);
    sc(0, CMD_BURST_KIND, 36'h0_0000_0002);
    burst_det = 0;
    st(3);
    burst_det = 1;
    st(2);
    burst_det = 0;
    st(5);
    burst_det = 1;
    wbt(24'h00_0006);
  endtask
  initial begin
    st(10);
    reset = 0;
    st(1);
    init_chk();
    t_codes();
    t_freq();
    t_second();
    t_preset();
    t_aux();
    t_burst();
    give_verdict();
  end
endmodule
bind csd_decoder csd_checker #(.FMAX_MHZ(FMAX_MHZ)) csd_checker_inst (.clk, .reset, .cmd_valid,
  .cmd_query, .cmd_code, .cmd_arg, .preset, .pass_fail, .template_en, .count_end, .int_gate,
  .acq_busy, .aux_sel, .man_atten_code, .man_freq_mhz, .resp_valid, .exe_err,
  .burst_time_valid, .aux_out);
